//--- pcb_cfg_pkg.sv
// Constants for the two-function card bridge configuration header
package pcb_cfg_pkg;
  localparam int unsigned NUM_FUNC = 2;
  localparam int unsigned HDR_BYTES = 256;
  localparam int unsigned IDX_W = 6;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_MAKER_CODE = 8'h00;
  localparam logic [7:0] OFF_BUS_IF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_SILICON_REVISION = 8'h08;
  localparam logic [7:0] OFF_LINE_SIZE_HINT = 8'h0c;
  localparam logic [7:0] OFF_SOCKET_WINDOW_BASE = 8'h10;
  localparam logic [7:0] OFF_FIRST_CAP_LINK = 8'h14;
  localparam logic [7:0] OFF_UPSTREAM_BUS_NUM = 8'h18;
  localparam logic [7:0] OFF_MEM_WINDOW0_LOW = 8'h1c;
  localparam logic [7:0] OFF_MEM_WINDOW0_HIGH = 8'h20;
  localparam logic [7:0] OFF_MEM_WINDOW1_LOW = 8'h24;
  localparam logic [7:0] OFF_MEM_WINDOW1_HIGH = 8'h28;
  localparam logic [7:0] OFF_IO_WINDOW1_LOW = 8'h34;
  localparam logic [7:0] OFF_IO_WINDOW1_HIGH = 8'h38;
  localparam logic [7:0] OFF_IRQ_ROUTE_NUMBER = 8'h3c;
  localparam logic [7:0] OFF_BOARD_MAKER_CODE = 8'h40;
  localparam logic [7:0] OFF_LEGACY_CARD_BASE = 8'h44;
  localparam logic [7:0] OFF_DEVICE_SETUP = 8'h80;
  localparam logic [7:0] OFF_PIN_FUNC_ROUTING = 8'h8c;
  localparam logic [7:0] OFF_RETRY_FLAGS = 8'h90;
  localparam logic [7:0] OFF_CAPABILITY_TAG = 8'ha0;
  localparam logic [7:0] OFF_POWER_STATE_CTRL = 8'ha4;
  localparam logic [7:0] OFF_WAKE_EVENT_FLAGS = 8'ha8;
  localparam logic [7:0] OFF_AUX_PIN_INPUTS = 8'hac;
  localparam logic [7:0] OFF_TWO_WIRE_BYTE = 8'hb0;
  // Field positions
  localparam int unsigned WAKE_EN_BIT = 8;
  localparam int unsigned WAKE_STAT_BIT = 15;
  localparam int unsigned KICK_BIT = 0;
  // Read-only contents and register reset value
  localparam logic [7:0] CAP_TAG_VAL = 8'h01;
  localparam logic [7:0] CAP_NEXT_VAL = 8'h00;
  localparam logic [15:0] POWER_CAPS_VAL = 16'h0002;
  localparam logic [7:0] IRQ_PIN_F0 = 8'h01;
  localparam logic [7:0] IRQ_PIN_F1 = 8'h02;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
endpackage

//--- pcb_cfg_bank.sv
// Configuration register bank of a two-function card bridge
// Summary of operation
// RL1: Each function owns its own 256-byte header reached by configuration cycles.
// RL2: Two functions, 0 and 1, each with bridge-type header and own copies.
// RL3: Device-global bits exist only in function 0; function 1 does not map them.
// RL4: Writable fields hold whatever value the host writes.
// RL5: Set-type fields go to 1 on a written 1; written 0 does nothing.
// RL6: Clear-type fields go to 0 on a written 1; written 0 does nothing.
// RL7: Update-type fields change from hardware without any host write.
// RL8: Cold-boot reset returns every register to default regardless of wake enable.
// RL9: Suspend blocks cold-boot reset so register contents are kept.
// RL10: Reserved offsets read zero and ignore writes, access still completes.
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_bank #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5678, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h01, // Arbitrary value
  parameter logic [23:0] FUNCTION_CLASS = 24'h000000,
  parameter logic [7:0] HEADER_LAYOUT = 8'h82
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cold_boot_reset_in_n_i,
  input wire logic host_bus_reset_in_n_i,
  input wire logic suspend_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic [15:0] status_evt_f0_i,
  input wire logic [15:0] status_evt_f1_i,
  input wire logic [1:0] pme_evt_i,
  input wire logic [15:0] wake_evt_i,
  input wire logic [15:0] aux_in_i,
  input wire logic kick_done_i,
  output logic [15:0] cmd_f0_o,
  output logic [15:0] cmd_f1_o,
  output logic [31:0] setup_o,
  output logic [15:0] aux_out_o,
  output logic kick_o,
  output logic wake_request_o
);

  localparam int unsigned NF = pcb_cfg_pkg::NUM_FUNC;
  localparam int unsigned NW = pcb_cfg_pkg::HDR_BYTES / 4;

  if (NF != 2 || NW != (1 << pcb_cfg_pkg::IDX_W)) begin : g_bad_geometry
    $error("pcb_cfg_bank: header geometry not supported");
  end

  typedef enum {MK_RW, MK_W1C, MK_W1S, MK_COLD, MK_CTX} pcb_mask_t;

  function automatic logic [5:0] ix(input logic [7:0] off);
    ix = off[7:2];
  endfunction

  // Per-word field masks; zero everywhere reserved, and for globals in function 1
  function automatic logic [31:0] fmask(input pcb_mask_t k, input logic f, input logic [5:0] i);
    logic [31:0] rw, c, s, cold, ctx;
    rw = 32'h0;
    c = 32'h0;
    s = 32'h0;
    cold = 32'h0;
    ctx = 32'h0;
    case (i)
      ix(pcb_cfg_pkg::OFF_BUS_IF_CONTROL): begin
        rw = 32'h0000_0167;
        c = 32'hf900_0000;
        cold = 32'hf900_0000;
      end
      ix(pcb_cfg_pkg::OFF_LINE_SIZE_HINT): rw = 32'h0000_ffff;
      ix(pcb_cfg_pkg::OFF_SOCKET_WINDOW_BASE): rw = 32'hffff_f000;
      ix(pcb_cfg_pkg::OFF_FIRST_CAP_LINK): begin
        c = 32'hf900_0000;
        cold = 32'hf900_0000;
      end
      ix(pcb_cfg_pkg::OFF_UPSTREAM_BUS_NUM): rw = 32'hffff_ffff;
      ix(pcb_cfg_pkg::OFF_MEM_WINDOW0_LOW), ix(pcb_cfg_pkg::OFF_MEM_WINDOW0_HIGH),
      ix(pcb_cfg_pkg::OFF_MEM_WINDOW1_LOW), ix(pcb_cfg_pkg::OFF_MEM_WINDOW1_HIGH):
        rw = 32'hffff_f000;
      ix(pcb_cfg_pkg::OFF_IO_WINDOW1_LOW), ix(pcb_cfg_pkg::OFF_IO_WINDOW1_HIGH):
        rw = 32'hffff_fffc;
      ix(pcb_cfg_pkg::OFF_IRQ_ROUTE_NUMBER): begin
        rw = 32'h07ff_00ff;
        ctx = 32'h0040_0000;
      end
      ix(pcb_cfg_pkg::OFF_BOARD_MAKER_CODE): begin
        rw = 32'hffff_ffff;
        cold = 32'hffff_ffff;
      end
      ix(pcb_cfg_pkg::OFF_LEGACY_CARD_BASE): begin
        rw = 32'hffff_fffe;
        cold = 32'hffff_fffe;
      end
      ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL): begin
        rw = 32'h0000_0103;
        c = 32'h0000_8000;
        ctx = 32'h0000_8100;
      end
      ix(pcb_cfg_pkg::OFF_DEVICE_SETUP): if (!f) begin // see RL3
        rw = 32'hefff_ef7e;
        s = 32'h0000_0001;
        cold = 32'hefff_e87f;
        ctx = 32'h0000_0700;
      end
      ix(pcb_cfg_pkg::OFF_PIN_FUNC_ROUTING): if (!f) begin // see RL3
        rw = 32'h0fff_ffff;
        cold = 32'h0fff_ffff;
      end
      ix(pcb_cfg_pkg::OFF_RETRY_FLAGS): if (!f) begin // see RL3
        rw = 32'hffff_ff00;
        c = 32'h0000_00ea;
        cold = 32'hffff_ffea;
      end
      ix(pcb_cfg_pkg::OFF_WAKE_EVENT_FLAGS): if (!f) begin // see RL3
        rw = 32'hffff_0000;
        c = 32'h0000_ffff;
        cold = 32'hc91f_c000;
      end
      ix(pcb_cfg_pkg::OFF_AUX_PIN_INPUTS): if (!f) begin // see RL3
        rw = 32'hffff_0000;
        cold = 32'h001f_0000;
      end
      ix(pcb_cfg_pkg::OFF_TWO_WIRE_BYTE): if (!f) begin // see RL3
        rw = 32'h00ff_ffff;
        cold = 32'h00ff_ffff;
      end
      default: rw = 32'h0; // see RL10
    endcase
    case (k)
      MK_RW: fmask = rw;
      MK_W1C: fmask = c;
      MK_W1S: fmask = s;
      MK_COLD: fmask = cold;
      MK_CTX: fmask = ctx;
      default: fmask = 32'h0;
    endcase
  endfunction

  // Fixed read-only content of each word
  function automatic logic [31:0] roval(input logic f, input logic [5:0] i);
    case (i)
      ix(pcb_cfg_pkg::OFF_MAKER_CODE): roval = {PART_CODE, MAKER_CODE};
      ix(pcb_cfg_pkg::OFF_SILICON_REVISION): roval = {FUNCTION_CLASS, SILICON_REVISION};
      ix(pcb_cfg_pkg::OFF_LINE_SIZE_HINT): roval = {8'h00, HEADER_LAYOUT, 16'h0000};
      ix(pcb_cfg_pkg::OFF_FIRST_CAP_LINK): roval = {24'h0, pcb_cfg_pkg::OFF_CAPABILITY_TAG};
      ix(pcb_cfg_pkg::OFF_IRQ_ROUTE_NUMBER):
        roval = {16'h0, (f ? pcb_cfg_pkg::IRQ_PIN_F1 : pcb_cfg_pkg::IRQ_PIN_F0), 8'h00};
      ix(pcb_cfg_pkg::OFF_CAPABILITY_TAG):
        roval = {pcb_cfg_pkg::POWER_CAPS_VAL, pcb_cfg_pkg::CAP_NEXT_VAL, pcb_cfg_pkg::CAP_TAG_VAL};
      default: roval = 32'h0;
    endcase
  endfunction

  // Each function keeps its own copy; unused bits are constant and trim away
  logic [31:0] word_reg [NF][NW]; // see RL1 see RL2
  logic [31:0] rdata_next;
  logic cold_act;
  logic host_act;
  logic [5:0] req_idx;
  logic [31:0] be_mask;

  // Suspend holds off the cold-boot reset so state survives power-down entry
  assign cold_act = !cold_boot_reset_in_n_i && !suspend_i; // see RL9
  assign host_act = !host_bus_reset_in_n_i;
  assign req_idx = cfg_addr_i[7:2];
  assign be_mask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    logic [31:0] v;
    logic [31:0] keep;
    logic [31:0] wm;
    logic pme_en;
    if (!rst_n_i) begin
      for (int f = 0; f < NF; f++) begin
        for (int i = 0; i < NW; i++) begin
          word_reg[f][i] <= pcb_cfg_pkg::RESET_VAL;
        end
      end
    end else begin
      for (int f = 0; f < NF; f++) begin
        for (int i = 0; i < NW; i++) begin
          v = word_reg[f][i];
          wm = cfg_wdata_i & be_mask;
          // Power words are per function; only the global setup word follows function 0
          pme_en = word_reg[f][ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL)][pcb_cfg_pkg::WAKE_EN_BIT];
          if (i == int'(ix(pcb_cfg_pkg::OFF_DEVICE_SETUP))) begin
            pme_en = word_reg[0][ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL)][pcb_cfg_pkg::WAKE_EN_BIT];
          end
          keep = fmask(MK_COLD, f[0], i[5:0]) | (pme_en ? fmask(MK_CTX, f[0], i[5:0]) : 32'h0);
          if (cold_act) begin
            v = pcb_cfg_pkg::RESET_VAL; // see RL8
          end else if (host_act) begin
            v = v & keep;
          end else begin
            if (f == 0 && i == int'(ix(pcb_cfg_pkg::OFF_DEVICE_SETUP)) && kick_done_i) begin
              v[pcb_cfg_pkg::KICK_BIT] = 1'b0;
            end
            if (cfg_req_i && cfg_we_i && cfg_func_i == f[0] && req_idx == i[5:0]) begin
              v = (v & ~(be_mask & fmask(MK_RW, f[0], i[5:0])))
                | (wm & fmask(MK_RW, f[0], i[5:0])); // see RL4
              v = v & ~(wm & fmask(MK_W1C, f[0], i[5:0])); // see RL6
              v = v | (wm & fmask(MK_W1S, f[0], i[5:0])); // see RL5
            end
            // Hardware sets come last so an event beats a same-cycle clear
            if (i == int'(ix(pcb_cfg_pkg::OFF_BUS_IF_CONTROL))) begin
              v = v | ({(f == 0 ? status_evt_f0_i : status_evt_f1_i), 16'h0}
                & fmask(MK_W1C, f[0], i[5:0])); // see RL7
            end
            if (i == int'(ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL)) && pme_evt_i[f]) begin
              v[pcb_cfg_pkg::WAKE_STAT_BIT] = 1'b1; // see RL7
            end
            if (f == 0 && i == int'(ix(pcb_cfg_pkg::OFF_WAKE_EVENT_FLAGS))) begin
              v = v | {16'h0, wake_evt_i}; // see RL7
            end
          end
          word_reg[f][i] <= v;
        end
      end
    end
  end

  always_comb begin
    rdata_next = roval(cfg_func_i, req_idx)
      | (word_reg[cfg_func_i][req_idx] & (fmask(MK_RW, cfg_func_i, req_idx)
      | fmask(MK_W1C, cfg_func_i, req_idx) | fmask(MK_W1S, cfg_func_i, req_idx)));
    if (!cfg_func_i && req_idx == ix(pcb_cfg_pkg::OFF_AUX_PIN_INPUTS)) begin
      rdata_next = rdata_next | {16'h0, aux_in_i}; // see RL7
    end
  end

  // Every access, reserved or not, is answered one cycle later
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0;
    end else begin
      cfg_ack_o <= cfg_req_i; // see RL10
      if (cfg_req_i && !cfg_we_i) begin
        cfg_rdata_o <= rdata_next;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    logic [31:0] pm0, pm1, wk;
    if (!rst_n_i) begin
      wake_request_o <= 1'b0;
    end else begin
      pm0 = word_reg[0][ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL)];
      pm1 = word_reg[1][ix(pcb_cfg_pkg::OFF_POWER_STATE_CTRL)];
      wk = word_reg[0][ix(pcb_cfg_pkg::OFF_WAKE_EVENT_FLAGS)];
      wake_request_o <= (pm0[pcb_cfg_pkg::WAKE_STAT_BIT] && pm0[pcb_cfg_pkg::WAKE_EN_BIT])
        || (pm1[pcb_cfg_pkg::WAKE_STAT_BIT] && pm1[pcb_cfg_pkg::WAKE_EN_BIT])
        || (|(wk[15:0] & wk[31:16]));
    end
  end

  assign cmd_f0_o = word_reg[0][ix(pcb_cfg_pkg::OFF_BUS_IF_CONTROL)][15:0];
  assign cmd_f1_o = word_reg[1][ix(pcb_cfg_pkg::OFF_BUS_IF_CONTROL)][15:0];
  assign setup_o = word_reg[0][ix(pcb_cfg_pkg::OFF_DEVICE_SETUP)];
  assign kick_o = word_reg[0][ix(pcb_cfg_pkg::OFF_DEVICE_SETUP)][pcb_cfg_pkg::KICK_BIT];
  assign aux_out_o = word_reg[0][ix(pcb_cfg_pkg::OFF_AUX_PIN_INPUTS)][31:16];

endmodule
`default_nettype wire

//--- pcb_cfg_monitor.sv
// Port checker for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cold_boot_reset_in_n_i,
  input wire logic host_bus_reset_in_n_i,
  input wire logic suspend_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_ack_o,
  input wire logic kick_done_i,
  input wire logic [31:0] setup_o,
  input wire logic [15:0] aux_out_o,
  input wire logic kick_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Writes only count while neither reset is active
  logic live;
  logic wr0;
  assign live = cold_boot_reset_in_n_i && host_bus_reset_in_n_i;
  assign wr0 = cfg_req_i && cfg_we_i && !cfg_func_i && live;
  a_ack_after_req: assert property (cfg_req_i |=> cfg_ack_o)
    else $error("ack missing after request");
  a_ack_no_spurious: assert property (!cfg_req_i |=> !cfg_ack_o)
    else $error("ack without request");
  a_rdata_holds: assert property (!(cfg_req_i && !cfg_we_i) && live |=> $stable(cfg_rdata_o))
    else $error("read data changed without read");
  a_kick_sets: assert property (wr0 && cfg_addr_i[7:2] == 6'h20 && cfg_be_i[0] && cfg_wdata_i[0]
    |=> kick_o)
    else $error("kick not set by write of one");
  a_kick_holds: assert property (kick_o && !kick_done_i && live |=> kick_o)
    else $error("kick lost without done");
  a_kick_done_clears: assert property (kick_o && kick_done_i && host_bus_reset_in_n_i
    && !(cfg_req_i && cfg_we_i)
    |=> !kick_o)
    else $error("kick not cleared by done");
  a_aux_write_holds: assert property (wr0 && cfg_addr_i[7:2] == 6'h2b && cfg_be_i[3:2] == 2'b11
    |=> aux_out_o == $past(cfg_wdata_i[31:16]))
    else $error("aux outputs differ from written value");
  a_func1_global_drop: assert property (cfg_req_i && cfg_we_i && cfg_func_i && live
    |=> $stable(aux_out_o))
    else $error("function 1 write reached a global word");
  a_cold_boot_clears: assert property (!cold_boot_reset_in_n_i && !suspend_i
    |=> setup_o == 32'h0 && aux_out_o == 16'h0)
    else $error("cold boot reset left state");
  a_suspend_keeps: assert property (!cold_boot_reset_in_n_i && suspend_i && host_bus_reset_in_n_i
    && !cfg_req_i && !kick_done_i |=> $stable(setup_o) && $stable(aux_out_o))
    else $error("state lost under suspend");
  a_reserved_zero: assert property (cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] inside {[6'h12:6'h1f]}
    |=> cfg_rdata_o == 32'h0)
    else $error("reserved offset read nonzero");
  c_kick: cover property (wr0 && cfg_addr_i[7:2] == 6'h20 ##1 kick_o);
  c_suspend: cover property (!cold_boot_reset_in_n_i && suspend_i);
  c_func1: cover property (cfg_req_i && cfg_func_i);
endmodule
bind pcb_cfg_bank pcb_cfg_monitor u_mon (.ref_clk_i, .rst_n_i, .cold_boot_reset_in_n_i,
  .host_bus_reset_in_n_i, .suspend_i, .cfg_req_i, .cfg_we_i, .cfg_func_i, .cfg_addr_i,
  .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .kick_done_i, .setup_o, .aux_out_o, .kick_o);
`default_nettype wire

//--- pcb_host_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pcb_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  input wire logic slow_i,
  output logic req_o = 1'b0,
  output logic we_o = 1'b0,
  output logic func_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [3:0] be_o = 4'h0,
  output logic [31:0] wdata_o = 32'h0
);
  task automatic access(input logic we, input logic fn, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    repeat (slow_i ? 3 : 1) @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    func_o <= fn;
    addr_o <= a;
    be_o <= be;
    wdata_o <= wd;
    @(posedge clk_i);
    // Scrambled once taken, so a late sample by the bank shows up
    req_o <= 1'b0;
    addr_o <= ~a;
    be_o <= ~be;
    wdata_o <= ~wd;
    // The registered answer is sampled at the next edge, while it stands
    @(posedge clk_i);
    while (!ack_i && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    rd = ack_i ? rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule
`default_nettype wire

//--- pcb_cfg_bank_bench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_bank_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cold_n = 1'b1;
  logic host_n = 1'b1;
  logic susp = 1'b0;
  logic kick_done = 1'b0;
  logic slow = 1'b0;
  logic [15:0] wake_evt = 16'h0;
  logic [15:0] st_evt0 = 16'h0;
  logic [15:0] st_evt1 = 16'h0;
  logic [1:0] pme_evt = 2'b00;
  logic [15:0] aux_in = 16'h0;
  logic req, we, fn, ack, kick, wake;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, setup, got, v, m;
  logic [15:0] aux_out, cmd0, cmd1;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0000c579;
  always #2.5 ref_clk = ~ref_clk;
  pcb_cfg_bank DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .cold_boot_reset_in_n_i(cold_n),
    .host_bus_reset_in_n_i(host_n), .suspend_i(susp), .cfg_req_i(req), .cfg_we_i(we),
    .cfg_func_i(fn), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
    .cfg_ack_o(ack), .status_evt_f0_i(st_evt0), .status_evt_f1_i(st_evt1), .pme_evt_i(pme_evt),
    .wake_evt_i(wake_evt), .aux_in_i(aux_in), .kick_done_i(kick_done), .cmd_f0_o(cmd0),
    .cmd_f1_o(cmd1), .setup_o(setup), .aux_out_o(aux_out), .kick_o(kick), .wake_request_o(wake));
  pcb_host_model u_host (.clk_i(ref_clk), .ack_i(ack), .rdata_i(rdata), .slow_i(slow),
    .req_o(req), .we_o(we), .func_o(fn), .addr_o(addr), .be_o(be), .wdata_o(wd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic f, input logic [7:0] a, input logic [31:0] d);
    u_host.access(1'b1, f, a, 4'hf, d, got);
  endtask
  task automatic rdc(input string nm, input logic f, input logic [7:0] a, input logic [31:0] e);
    u_host.access(1'b0, f, a, 4'h0, 32'h0, got);
    check(nm, got, e);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  initial begin
    tick(5);
    rst_n <= 1'b1;
    rdc("hdr reset", 1'b0, 8'h0c, 32'h0082_0000);
    v = rnd();
    m = rnd();
    wr(1'b0, 8'h0c, v);
    wr(1'b1, 8'h0c, m);
    rdc("f0 hint", 1'b0, 8'h0c, {16'h0082, v[15:0]});
    rdc("f1 hint", 1'b1, 8'h0c, {16'h0082, m[15:0]});
    $display("test copies done");
    aux_in <= v[31:16];
    wr(1'b0, 8'hac, m);
    check("aux_out", {16'h0, aux_out}, {16'h0, m[31:16]});
    rdc("aux f0", 1'b0, 8'hac, {m[31:16], v[31:16]});
    wr(1'b1, 8'hac, v);
    rdc("aux f1", 1'b1, 8'hac, 32'h0);
    rdc("aux kept", 1'b0, 8'hac, {m[31:16], v[31:16]});
    $display("test global done");
    tick(1);
    wake_evt <= 16'h8001;
    tick(1);
    wake_evt <= 16'h0;
    rdc("flags set", 1'b0, 8'ha8, 32'h0000_8001);
    wr(1'b0, 8'ha8, 32'h0000_0001);
    rdc("flags clr", 1'b0, 8'ha8, 32'h0000_8000);
    wr(1'b0, 8'ha8, 32'h8000_0000);
    rdc("flags keep", 1'b0, 8'ha8, 32'h8000_8000);
    check("wake", {31'h0, wake}, 32'h1);
    $display("test flags done");
    slow <= 1'b1;
    wr(1'b0, 8'h80, 32'h1);
    check("kick set", {31'h0, kick}, 32'h1);
    wr(1'b0, 8'h80, 32'h0);
    check("kick kept", {31'h0, kick}, 32'h1);
    tick(1);
    kick_done <= 1'b1;
    tick(1);
    kick_done <= 1'b0;
    rdc("kick done", 1'b0, 8'h80, 32'h0);
    wr(1'b0, 8'h48, 32'hffff_ffff);
    rdc("reserved", 1'b0, 8'h48, 32'h0);
    $display("test set-type done");
    slow <= 1'b0;
    wr(1'b0, 8'h80, 32'h1);
    wr(1'b0, 8'ha4, 32'h0000_0100);
    tick(1);
    susp <= 1'b1;
    tick(1);
    cold_n <= 1'b0;
    tick(3);
    cold_n <= 1'b1;
    tick(1);
    susp <= 1'b0;
    rdc("setup held", 1'b0, 8'h80, 32'h1);
    rdc("aux held", 1'b0, 8'hac, {m[31:16], v[31:16]});
    tick(1);
    cold_n <= 1'b0;
    tick(2);
    cold_n <= 1'b1;
    rdc("aux cold", 1'b0, 8'hac, {16'h0, v[31:16]});
    rdc("f1 cold", 1'b1, 8'h0c, 32'h0082_0000);
    check("wake cold", {31'h0, wake}, 32'h0);
    $display("test resets done");
    pme_evt <= 2'b10;
    tick(1);
    pme_evt <= 2'b00;
    rdc("pm event", 1'b1, 8'ha4, 32'h0000_8000);
    check("wake masked", {31'h0, wake}, 32'h0);
    wr(1'b1, 8'ha4, 32'h0000_0100);
    wr(1'b1, 8'h3c, 32'hffff_ffff);
    rdc("bridge f1", 1'b1, 8'h3c, 32'h07ff_02ff);
    wr(1'b1, 8'h40, v);
    wr(1'b1, 8'h04, 32'h0000_0005);
    wr(1'b0, 8'h04, 32'hffff_ffff);
    check("cmd0", {16'h0, cmd0}, 32'h0000_0167);
    check("cmd1", {16'h0, cmd1}, 32'h0000_0005);
    check("wake pm", {31'h0, wake}, 32'h1);
    st_evt0 <= 16'h0800;
    st_evt1 <= 16'h8100;
    tick(1);
    st_evt0 <= 16'h0;
    st_evt1 <= 16'h0;
    rdc("status f1", 1'b1, 8'h04, 32'h8100_0005);
    rdc("status f0", 1'b0, 8'h04, 32'h0800_0167);
    wr(1'b1, 8'h04, 32'h8000_0005);
    rdc("status clr", 1'b1, 8'h04, 32'h0100_0005);
    host_n <= 1'b0;
    tick(2);
    host_n <= 1'b1;
    rdc("ctx kept", 1'b1, 8'h3c, 32'h0040_0200);
    rdc("pm kept", 1'b1, 8'ha4, 32'h0000_8100);
    rdc("board kept", 1'b1, 8'h40, v);
    rdc("status kept", 1'b1, 8'h04, 32'h0100_0000);
    check("cmd0 host", {16'h0, cmd0}, 32'h0);
    wr(1'b1, 8'ha4, 32'h0000_8000);
    host_n <= 1'b0;
    tick(2);
    host_n <= 1'b1;
    rdc("ctx lost", 1'b1, 8'h3c, 32'h0000_0200);
    $display("test host reset done");
    tally_and_finish();
  end
  initial begin
    #(20000 * 5);
    errors++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
